// ---- core/fem_params.svh ----
`ifndef FEM_PARAMS_SVH
`define FEM_PARAMS_SVH

// =====================================================
// register offsets
`define FEM_OFS_PORT0      8'h00
`define FEM_OFS_CTRL       8'h04
`define FEM_OFS_STATUS     8'h08
`define FEM_OFS_TXPWR      8'h0C
`define FEM_OFS_TEST_ROUTE 8'h10

// =====================================================
// field positions
`define FEM_BIT_PATH_SEL   2
`define FEM_BIT_SHUTDOWN   3
`define FEM_BIT_AUTO_EN    0
`define FEM_BIT_SLEEP_REQ  1
`define FEM_BIT_EXT_RANGE  2
`define FEM_BIT_BYP_REQ    3
`define FEM_BIT_HW_ROUTE   0

// =====================================================
// reset values and codes
`define FEM_PORT0_RST      8'h00
`define FEM_CTRL_RST       4'h0
`define FEM_TXPWR_RST      4'h6
`define FEM_ROUTE_KEY      32'h0000_0001
`define FEM_SETTLE_NS      100
`define FEM_SETTLE_CYC     ((`FEM_SETTLE_NS + 19) / 20)

`endif

// ---- core/fem_pkg.sv ----
package fem_pkg;
   typedef enum logic [1:0] {
      FEM_ALL_OFF = 2'h0,
      FEM_STANDBY = 2'h1,
      FEM_BYPASS  = 2'h2,
      FEM_HIGH    = 2'h3
   } fem_mode_t;

   typedef enum {FEM_ST_IDLE, FEM_ST_WAIT_RF, FEM_ST_SETTLE} fem_seq_t;

   typedef struct packed {
      logic       shutdown;
      logic       path_sel;
   } fem_lines_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [31:0] wdata;
   } fem_bus_t;
endpackage

// ---- core/fem_mode_enc.sv ----
`timescale 1ns/1ps
`default_nettype none
module fem_mode_enc
   import fem_pkg::*;
(
   input  wire fem_mode_t  mode_i,
   output var fem_lines_t  lines_o
);
   always_comb begin
      unique case (mode_i)
         FEM_ALL_OFF: lines_o = '{shutdown: 1'b0, path_sel: 1'b0};
         FEM_STANDBY: lines_o = '{shutdown: 1'b0, path_sel: 1'b1};
         FEM_BYPASS:  lines_o = '{shutdown: 1'b1, path_sel: 1'b0};
         FEM_HIGH:    lines_o = '{shutdown: 1'b1, path_sel: 1'b1};
      endcase
   end
endmodule
`default_nettype wire

// ---- core/fem_ctrl.sv ----
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "fem_params.svh"
module fem_ctrl
   import fem_pkg::*;
#(
   parameter int SETTLE_CYC = `FEM_SETTLE_CYC
)(
   input  wire logic        mclk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        clk_en_i,
   input  wire logic [7:0]  addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic [31:0]      rdata_o,
   input  wire logic        ll_tx_en_i,
   input  wire logic        ll_rx_en_i,
   input  wire logic        radio_busy_i,
   input  wire logic        radio_stack_up_event_i,
   input  wire logic        wake_i,
   output logic [7:0]       port0_o,
   output logic             amp_shutdown_line_o,
   output logic             path_select_line_o,
   output logic             pa_en_o,
   output logic             lna_en_o,
   output logic [3:0]       tx_power_o
);
   // =====================================================
   // elaboration check
   // settle counter is eight bits wide and must load a non-zero count
   if (SETTLE_CYC < 1 || SETTLE_CYC > 255) begin : g_bad_settle
      $error("SETTLE_CYC out of range");
   end

   typedef struct packed {
      logic [7:0]  port0;
      logic [3:0]  ctrl;
      logic        stack_up;
      logic        hw_route;
      logic        byp_pend;
      fem_seq_t    seq;
      logic [7:0]  cnt;
      logic [31:0] rdata;
   } fem_state_t;

   fem_state_t state_reg;
   fem_state_t state_next;
   fem_mode_t  req_mode;
   fem_lines_t lines;

   // =====================================================
   // mode to line encoding
   // lines follow the registered port bits, so they never glitch with a strobe
   assign req_mode = fem_mode_t'({state_reg.port0[`FEM_BIT_SHUTDOWN], state_reg.port0[`FEM_BIT_PATH_SEL]});

   fem_mode_enc u_enc (
      .mode_i  (req_mode),
      .lines_o (lines)
   );

   // =====================================================
   // next state
   always_comb begin
      state_next       = state_reg;
      state_next.rdata = 32'h0;
      if (radio_stack_up_event_i) begin
         state_next.stack_up = 1'b1;
      end
      if (wr_i) begin
         unique case (addr_i)
            `FEM_OFS_PORT0: begin
               if (wdata_i[`FEM_BIT_SHUTDOWN:`FEM_BIT_PATH_SEL] == 2'(FEM_BYPASS) && radio_busy_i) begin
                  state_next.byp_pend = 1'b1;
                  state_next.port0    = {wdata_i[7:4], state_reg.port0[3:2], wdata_i[1:0]};
               end else begin
                  state_next.byp_pend = 1'b0;
                  state_next.port0    = wdata_i[7:0];
               end
            end
            `FEM_OFS_CTRL: state_next.ctrl = wdata_i[3:0];
            `FEM_OFS_TEST_ROUTE: begin
               if (state_reg.stack_up && wdata_i == `FEM_ROUTE_KEY) begin
                  state_next.hw_route = 1'b1;
               end
            end
            default: ;
         endcase
      end
      if (state_reg.byp_pend && !radio_busy_i && !(wr_i && addr_i == `FEM_OFS_PORT0)) begin
         state_next.port0[`FEM_BIT_SHUTDOWN] = 1'b1;
         state_next.port0[`FEM_BIT_PATH_SEL] = 1'b0;
         state_next.byp_pend = 1'b0;
      end
      if (state_reg.ctrl[`FEM_BIT_AUTO_EN]) begin
         unique case (state_reg.seq)
            FEM_ST_IDLE: begin
               if (state_reg.ctrl[`FEM_BIT_SLEEP_REQ]) begin
                  state_next.port0[`FEM_BIT_SHUTDOWN] = 1'b0;
                  state_next.port0[`FEM_BIT_PATH_SEL] = 1'b1;
                  state_next.byp_pend = 1'b0;
                  // a fresh request written in this cycle wins over the clear
                  if (!(wr_i && addr_i == `FEM_OFS_CTRL && wdata_i[`FEM_BIT_SLEEP_REQ])) begin
                     state_next.ctrl[`FEM_BIT_SLEEP_REQ] = 1'b0;
                  end
                  state_next.seq = FEM_ST_WAIT_RF;
               end
            end
            FEM_ST_WAIT_RF: begin
               if (wake_i && state_reg.ctrl[`FEM_BIT_EXT_RANGE]) begin
                  state_next.port0[`FEM_BIT_SHUTDOWN] = 1'b1;
                  state_next.port0[`FEM_BIT_PATH_SEL] = 1'b1;
                  state_next.cnt = 8'(SETTLE_CYC);
                  state_next.seq = FEM_ST_SETTLE;
               end else if (wake_i && !radio_busy_i) begin
                  state_next.port0[`FEM_BIT_SHUTDOWN] = 1'b1;
                  state_next.port0[`FEM_BIT_PATH_SEL] = 1'b0;
                  state_next.cnt = 8'(SETTLE_CYC);
                  state_next.seq = FEM_ST_SETTLE;
               end
            end
            FEM_ST_SETTLE: begin
               if (state_reg.cnt <= 8'h01) begin
                  state_next.seq = FEM_ST_IDLE;
               end else begin
                  state_next.cnt = state_reg.cnt - 8'h01;
               end
            end
         endcase
      end
      if (rd_i) begin
         unique case (addr_i)
            `FEM_OFS_PORT0:  state_next.rdata = {24'h0, state_reg.port0};
            `FEM_OFS_CTRL:   state_next.rdata = {28'h0, state_reg.ctrl};
            `FEM_OFS_STATUS: state_next.rdata = {24'h0,
                                                 state_reg.seq == FEM_ST_SETTLE,
                                                 state_reg.seq == FEM_ST_WAIT_RF,
                                                 state_reg.byp_pend,
                                                 state_reg.stack_up,
                                                 state_reg.hw_route,
                                                 req_mode,
                                                 ll_tx_en_i};
            `FEM_OFS_TXPWR:  state_next.rdata = {28'h0, `FEM_TXPWR_RST};
            `FEM_OFS_TEST_ROUTE: state_next.rdata = {31'h0, state_reg.hw_route};
            default:         state_next.rdata = 32'h0;
         endcase
      end
   end

   // =====================================================
   // state register
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         state_reg <= '{port0:    `FEM_PORT0_RST,
                        ctrl:     `FEM_CTRL_RST,
                        stack_up: 1'b0,
                        hw_route: 1'b0,
                        byp_pend: 1'b0,
                        seq:      FEM_ST_IDLE,
                        cnt:      8'h00,
                        rdata:    32'h0};
      end else if (clk_en_i) begin
         state_reg <= state_next;
      end
   end

   // =====================================================
   // outputs
   assign rdata_o             = state_reg.rdata;
   assign port0_o             = state_reg.port0;
   assign amp_shutdown_line_o = lines.shutdown;
   assign path_select_line_o  = lines.path_sel;
   assign pa_en_o             = state_reg.hw_route & ll_tx_en_i;
   assign lna_en_o            = state_reg.hw_route & ll_rx_en_i;
   assign tx_power_o          = `FEM_TXPWR_RST;
endmodule
`default_nettype wire

// ---- verif/fem_amp_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// =====
// far-side amplifier: decodes the two control lines
module fem_amp_model (
   input  wire logic  shutdown_i,
   input  wire logic  path_sel_i,
   output logic [1:0] mode_o,
   output logic       radiating_o
);
   assign mode_o = {shutdown_i, path_sel_i};
   assign radiating_o = shutdown_i;
endmodule
`default_nettype wire

// ---- verif/fem_ctrl_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module fem_ctrl_sva #(
   parameter int SETTLE_CYC = 5
)(
   input wire logic        mclk_i,
   input wire logic        sys_rst_i,
   input wire logic        clk_en_i,
   input wire logic [7:0]  addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic        wr_i,
   input wire logic        rd_i,
   input wire logic [31:0] rdata_o,
   input wire logic        ll_tx_en_i,
   input wire logic        ll_rx_en_i,
   input wire logic        radio_busy_i,
   input wire logic        radio_stack_up_event_i,
   input wire logic [7:0]  port0_o,
   input wire logic        amp_shutdown_line_o,
   input wire logic        path_select_line_o,
   input wire logic        pa_en_o,
   input wire logic        lna_en_o,
   input wire logic [3:0]  tx_power_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);
   logic stack_seen_reg;
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) stack_seen_reg <= 1'b0;
      else if (radio_stack_up_event_i && clk_en_i) stack_seen_reg <= 1'b1;
   end
   sequence s_busy_not_byp;
      clk_en_i && radio_busy_i && !(amp_shutdown_line_o && !path_select_line_o);
   endsequence
   sequence s_sleep_req;
      clk_en_i && wr_i && addr_i == 8'h04 && wdata_i[1:0] == 2'h3;
   endsequence
   AST_PA_LL: assert property (pa_en_o |-> ll_tx_en_i) else $error("pa enable without link layer");
   AST_LNA_LL: assert property (lna_en_o |-> ll_rx_en_i) else $error("lna enable without link layer");
   AST_ROUTE: assert property ((pa_en_o || lna_en_o) |-> stack_seen_reg) else $error("route before stack");
   AST_TXPWR: assert property (tx_power_o == 4'h6) else $error("tx power code wrong");
   AST_SHUT_BIT: assert property (amp_shutdown_line_o == port0_o[3]) else $error("shutdown bit");
   AST_PATH_BIT: assert property (path_select_line_o == port0_o[2]) else $error("path bit");
   AST_NO_BYP_BUSY: assert property (s_busy_not_byp |=> !(amp_shutdown_line_o && !path_select_line_o))
      else $error("bypass entered while busy");
   AST_SLEEP_STBY: assert property (s_sleep_req |-> ##[1:2] (!amp_shutdown_line_o && path_select_line_o))
      else $error("no standby on sleep");
   AST_FREEZE: assert property (!clk_en_i |=> $stable(port0_o) && $stable(rdata_o))
      else $error("state moved while clock enable low");
   AST_RST_OFF: assert property (disable iff (1'b0) sys_rst_i |=> port0_o == 8'h00 && !pa_en_o && !lna_en_o)
      else $error("not off after reset");
endmodule
bind fem_ctrl fem_ctrl_sva #(.SETTLE_CYC(SETTLE_CYC)) fem_ctrl_sva_inst (.*);
`default_nettype wire

// ---- verif/fem_ctrl_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module fem_ctrl_test;
   logic mclk_i = 1'b0, sys_rst_i = 1'b1, clk_en_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, rd_q = 1'b0, wake_i = 1'b0;
   logic ll_tx_en_i = 1'b0, ll_rx_en_i = 1'b0, radio_busy_i = 1'b0, radio_stack_up_event_i = 1'b0;
   logic [7:0]  addr_i = 8'h00, port0_o;
   logic [31:0] wdata_i = 32'h0, rdata_o, d, exp_q[$];
   logic        amp_shutdown_line_o, path_select_line_o, pa_en_o, lna_en_o, radiating;
   logic [3:0]  tx_power_o;
   logic [1:0]  mode_seen;
   int          errors = 0, n_checks = 0, cycles = 0;
   always #10 mclk_i = ~mclk_i;
   fem_ctrl #(.SETTLE_CYC(5)) fem_ctrl_inst (.*);
   fem_amp_model fem_amp_model_inst (.shutdown_i(amp_shutdown_line_o), .path_sel_i(path_select_line_o),
      .mode_o(mode_seen), .radiating_o(radiating));
   // =====
   // tasks
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic close_out();
      if (errors == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      addr_i <= a; wdata_i <= v; wr_i <= 1'b1; rd_i <= 1'b0;
      @(posedge mclk_i);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      addr_i <= a; rd_i <= 1'b1; wr_i <= 1'b0;
      @(posedge mclk_i);
   endtask
   task automatic tick(input int n);
      wr_i <= 1'b0; rd_i <= 1'b0;
      repeat (n) @(posedge mclk_i);
   endtask
   // sample away from the edge so the outputs have settled
   task automatic st(input logic [1:0] m, input logic pa, input logic lna);
      @(negedge mclk_i);
      check("mode", {30'h0, mode_seen}, {30'h0, m});
      check("pa_en", {31'h0, pa_en_o}, {31'h0, pa});
      check("lna_en", {31'h0, lna_en_o}, {31'h0, lna});
      @(posedge mclk_i);
   endtask
   always @(posedge mclk_i) begin
      cycles <= cycles + 1;
      rd_q <= rd_i && clk_en_i && !sys_rst_i;
      if (rd_q) check("rdata", rdata_o, exp_q.pop_front());
      else if (cycles > 2) check("rdata_idle", rdata_o, 32'h0);
      if (cycles == 3000) begin
         errors++;
         close_out();
      end
   end
   // =====
   // scenarios
   initial begin
      void'($urandom(77725));
      repeat (12) @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      ll_tx_en_i <= 1'b1;
      ll_rx_en_i <= 1'b1;
      st(2'h0, 1'b0, 1'b0);
      check("txpwr", {28'h0, tx_power_o}, 32'h6);
      for (int m = 0; m < 4; m++) begin
         d = ($urandom & 32'hF3) | (m << 2);
         wr(8'h00, d);
         rd(8'h00, {24'h0, d[7:0]});
         tick(1);
         st(m[1:0], 1'b0, 1'b0);
      end
      wr(8'h10, 32'h1);
      tick(1);
      st(2'h3, 1'b0, 1'b0);
      radio_stack_up_event_i <= 1'b1;
      @(posedge mclk_i);
      radio_stack_up_event_i <= 1'b0;
      wr(8'h10, 32'h1);
      tick(1);
      st(2'h3, 1'b1, 1'b1);
      ll_tx_en_i <= 1'b0;
      st(2'h3, 1'b0, 1'b1);
      radio_busy_i <= 1'b1;
      wr(8'h00, 32'h08);
      tick(3);
      st(2'h3, 1'b0, 1'b1);
      radio_busy_i <= 1'b0;
      tick(3);
      st(2'h2, 1'b0, 1'b1);
      check("radiating", {31'h0, radiating}, 32'h1);
      wr(8'h04, 32'h7);
      tick(3);
      st(2'h1, 1'b0, 1'b1);
      wake_i <= 1'b1;
      tick(14);
      st(2'h3, 1'b0, 1'b1);
      wake_i <= 1'b0;
      rd(8'h08, 32'h1E);
      tick(1);
      // frozen clock enable ignores a write
      clk_en_i <= 1'b0;
      wr(8'h00, 32'h0);
      tick(2);
      st(2'h3, 1'b0, 1'b1);
      check("port0", {24'h0, port0_o}, 32'h0C);
      clk_en_i <= 1'b1;
      // wake without extended range lands in bypass
      wr(8'h04, 32'h3);
      tick(3);
      st(2'h1, 1'b0, 1'b1);
      wake_i <= 1'b1;
      tick(3);
      st(2'h2, 1'b0, 1'b1);
      wake_i <= 1'b0;
      // mid-run reset
      sys_rst_i <= 1'b1;
      tick(2);
      sys_rst_i <= 1'b0;
      st(2'h0, 1'b0, 1'b0);
      check("port0_rst", {24'h0, port0_o}, 32'h0);
      rd(8'h20, 32'h0);
      rd(8'h0C, 32'h6);
      tick(3);
      close_out();
   end
endmodule
`default_nettype wire
